// File: logic/tmsc_top.v
`timescale 1ns/1ps
`include "tmsc_defines.vh"
module tmsc_top #(
   parameter CYC_PER_MS = `TMSC_CYC_PER_MS
) (
   input wire pclk, // 50 MHz clock
   input wire presetn, // async reset, active low
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [7:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error
   input wire btn_arrive_n, // arrival button pin, low pressed
   input wire btn_depart_n, // departure button pin, low pressed
   input wire card_done, // card read finished pulse
   input wire [7:0] rx_addr, // address field of host frame
   input wire rx_addr_vld, // rx_addr valid pulse
   output reg addr_hit, // frame is for this terminal
   output reg firmware_service_mode, // service mode level
   output reg disp_show_addr, // display shows address
   output reg [7:0] disp_value, // address to display
   output reg disp_flip, // display turned 180 degrees
   output reg beep, // buzzer drive
   output reg bell_relay, // relay coil, high energised
   output reg event_depart // selected event, high departure
);
   // ==========================================================
   // state codes
   localparam ST_BOOT = 3'h0;
   localparam ST_SHOW = 3'h1;
   localparam ST_AWAIT = 3'h2;
   localparam ST_ASET = 3'h3;
   localparam ST_NORM = 3'h4;
   localparam ST_FW = 3'h5;
   localparam [11:0] SHOW_MS = `TMSC_SHOW_MS;
   localparam [11:0] AWAIT_MS = `TMSC_ADDR_WAIT_MS;
   localparam [11:0] BEEP_MS = `TMSC_BEEP_MS;
   localparam [12:0] OVR_MS = `TMSC_OVR_MS;
   localparam [9:0] MS_PER_S = `TMSC_MS_PER_S;
   localparam [10:0] MIN_DAY = `TMSC_MIN_PER_DAY;
   localparam [7:0] ADDR_MAX = 8'h0A;

   // ==========================================================
   // button synchroniser
   wire [1:0] btn_lvl; // filtered pin levels
   wire arr_p = ~btn_lvl[0]; // arrival pressed
   wire dep_p = ~btn_lvl[1]; // departure pressed
   reg arr_d_q; // previous arrival level
   reg dep_d_q; // previous departure level
   wire arr_edge = arr_p & ~arr_d_q; // arrival press
   wire dep_edge = dep_p & ~dep_d_q; // departure press
   tmsc_btn_sync #(.N(2)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din({btn_depart_n, btn_arrive_n}),
      .dout(btn_lvl)
   );

   // ==========================================================
   // millisecond and second enables
   reg [31:0] div_q; // clock divider
   reg [9:0] ms_q; // ms within second
   wire ms_tick = (div_q == CYC_PER_MS - 1); // one per ms
   wire s_tick = ms_tick & (ms_q == MS_PER_S - 10'h001); // one per s
   // divider chain
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 32'h0000_0000;
         ms_q <= 10'h000;
      end else if (ms_tick) begin
         div_q <= 32'h0000_0000;
         ms_q <= s_tick ? 10'h000 : ms_q + 10'h001;
      end else begin
         div_q <= div_q + 32'h0000_0001;
      end
   end

   // ==========================================================
   // apb slave, one wait state
   reg [3:0] ctrl_q; // mode, flip, weekly
   reg [7:0] addr_q; // network address
   reg [7:0] blen_q; // bell length in seconds
   reg [5:0] sec_q; // seconds
   reg [10:0] min_q; // minute of day
   reg [2:0] day_q; // weekday, 0 sunday
   wire acc = psel & penable & pready; // completing edge
   wire wr = acc & pwrite;
   wire hit_ctrl = (paddr == `TMSC_OFF_CTRL);
   wire hit_addr = (paddr == `TMSC_OFF_ADDR);
   wire hit_time = (paddr == `TMSC_OFF_TIME);
   wire hit_stat = (paddr == `TMSC_OFF_STAT);
   wire hit_blen = (paddr == `TMSC_OFF_BLEN);
   wire hit_bell = (paddr == `TMSC_OFF_BELL);
   wire hit_evt = (paddr == `TMSC_OFF_EVT);
   wire mapped = hit_ctrl | hit_addr | hit_time | hit_stat | hit_blen |
      hit_bell | hit_evt;
   reg [31:0] rd_d; // read mux
   // read mux, tables are write only
   always @* begin
      rd_d = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_d[3:0] = ctrl_q;
      end else if (hit_addr) begin
         rd_d[7:0] = addr_q;
      end else if (hit_time) begin
         rd_d[19:0] = {day_q, min_q, sec_q};
      end else if (hit_stat) begin
         rd_d[3:0] = {event_depart, bell_relay, firmware_service_mode,
            disp_show_addr};
      end else if (hit_blen) begin
         rd_d[7:0] = blen_q;
      end
   end
   // handshake and read capture
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         if (psel & penable & ~pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_d;
            pslverr <= ~mapped;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // ==========================================================
   // timekeeping, software may set it
   // time of day counter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_q <= 6'h00;
         min_q <= 11'h000;
         day_q <= 3'h0;
      end else if (wr & hit_time) begin
         sec_q <= pwdata[5:0];
         min_q <= pwdata[`TMSC_TIME_DAY_LSB-1:`TMSC_TIME_MIN_LSB];
         day_q <= pwdata[`TMSC_TIME_DAY_LSB+2:`TMSC_TIME_DAY_LSB];
      end else if (s_tick) begin
         sec_q <= (sec_q == 6'h3B) ? 6'h00 : sec_q + 6'h01;
         if (sec_q == 6'h3B) begin
            min_q <= (min_q == MIN_DAY - 11'h001) ? 11'h000 :
               min_q + 11'h001;
            if (min_q == MIN_DAY - 11'h001) begin
               day_q <= (day_q == 3'h6) ? 3'h0 : day_q + 3'h1;
            end
         end
      end
   end

   // ==========================================================
   // schedule tables and scan
   reg [4:0] scan_q; // scan index
   reg [4:0] scan_d1_q; // index of the entry now read
   reg bell_acc_q; // bell match this scan
   reg bell_m_q; // bell match last scan
   reg evt_acc_q; // event match this scan
   reg evt_val_q; // event of matching entry
   wire [11:0] bell_ent; // bell entry: en, minute
   wire [12:0] evt_ent; // event entry: en, event, minute
   wire [2:0] bday = ctrl_q[`TMSC_CTRL_WEEK] ? day_q : 3'h0;
   wire bell_m = bell_ent[11] & (bell_ent[10:0] == min_q);
   wire evt_m = evt_ent[12] & (evt_ent[10:0] == min_q);
   // daily uses day slot 0, weekly the weekday slot
   tmsc_tbl #(.AW(8), .DW(12)) u_bell (
      .pclk(pclk),
      .we(wr & hit_bell),
      .waddr(pwdata[`TMSC_ENT_IDX_LSB+7:`TMSC_ENT_IDX_LSB]),
      .wdata({pwdata[`TMSC_ENT_EN], pwdata[10:0]}),
      .raddr({bday, scan_q}),
      .rdata(bell_ent)
   );
   tmsc_tbl #(.AW(5), .DW(13)) u_evt (
      .pclk(pclk),
      .we(wr & hit_evt),
      .waddr(pwdata[`TMSC_ENT_IDX_LSB+4:`TMSC_ENT_IDX_LSB]),
      .wdata({pwdata[`TMSC_ENT_EN], pwdata[`TMSC_ENT_EVT], pwdata[10:0]}),
      .raddr(scan_q),
      .rdata(evt_ent)
   );
   reg evt_hit_q; // event entry matched last scan
   // continuous scan, result latched after entry 31
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_q <= 5'h00;
         scan_d1_q <= 5'h00;
         bell_acc_q <= 1'b0;
         bell_m_q <= 1'b0;
         evt_acc_q <= 1'b0;
         evt_val_q <= 1'b0;
         evt_hit_q <= 1'b0;
      end else begin
         scan_q <= scan_q + 5'h01;
         scan_d1_q <= scan_q;
         if (scan_d1_q == 5'h1F) begin
            bell_m_q <= bell_acc_q | bell_m;
            evt_hit_q <= evt_acc_q | evt_m;
            bell_acc_q <= 1'b0;
            evt_acc_q <= 1'b0;
         end else begin
            bell_acc_q <= bell_acc_q | bell_m;
            evt_acc_q <= evt_acc_q | evt_m;
         end
         if (evt_m) begin
            evt_val_q <= evt_ent[11];
         end
      end
   end

   // ==========================================================
   // boot mode and address setting
   reg [2:0] st_q; // mode state
   reg [11:0] ms_cnt_q; // ms counter for boot phases
   reg [2:0] cyc_q; // sync settle count
   reg [11:0] beep_q; // remaining beep ms
   // mode sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_BOOT;
         ms_cnt_q <= 12'h000;
         cyc_q <= 3'h0;
         beep_q <= 12'h000;
         addr_q <= `TMSC_ADDR_RST;
         ctrl_q <= `TMSC_CTRL_RST;
         blen_q <= `TMSC_BLEN_RST;
         firmware_service_mode <= 1'b0;
         disp_show_addr <= 1'b0;
         disp_value <= 8'h00;
         beep <= 1'b0;
         disp_flip <= 1'b0;
      end else begin
         if (ms_tick && beep_q != 12'h000) begin
            beep_q <= beep_q - 12'h001;
         end
         beep <= (beep_q != 12'h000);
         if (wr & hit_ctrl) begin
            ctrl_q <= pwdata[3:0];
         end
         if (wr & hit_blen) begin
            blen_q <= pwdata[7:0];
         end
         if (wr & hit_addr) begin
            addr_q <= pwdata[7:0];
         end
         disp_flip <= ctrl_q[`TMSC_CTRL_FLIP];
         case (st_q)
            ST_BOOT: begin
               cyc_q <= cyc_q + 3'h1;
               if (cyc_q == `TMSC_SYNC_CYC) begin
                  ms_cnt_q <= 12'h000;
                  disp_value <= addr_q;
                  if (arr_p) begin
                     st_q <= ST_FW;
                     firmware_service_mode <= 1'b1;
                  end else if (dep_p) begin
                     st_q <= ST_AWAIT;
                  end else begin
                     st_q <= ST_SHOW;
                     disp_show_addr <= 1'b1;
                  end
               end
            end
            ST_SHOW: begin
               if (ms_tick) begin
                  ms_cnt_q <= ms_cnt_q + 12'h001;
               end
               if (ms_cnt_q == SHOW_MS) begin
                  disp_show_addr <= 1'b0;
                  st_q <= ST_NORM;
               end
            end
            ST_AWAIT: begin
               if (ms_tick) begin
                  ms_cnt_q <= ms_cnt_q + 12'h001;
               end
               // start on a tick so the beep lasts whole ms
               if (ms_tick && ms_cnt_q == AWAIT_MS - 12'h001) begin
                  beep_q <= BEEP_MS;
                  disp_value <= addr_q;
                  disp_show_addr <= 1'b1;
                  st_q <= ST_ASET;
               end
            end
            ST_ASET: begin
               if (!dep_p) begin
                  addr_q <= disp_value;
                  disp_show_addr <= 1'b0;
                  st_q <= ST_NORM;
               end else if (arr_edge) begin
                  disp_value <= (disp_value >= ADDR_MAX) ? 8'h00 :
                     disp_value + 8'h01;
               end
            end
            ST_NORM: begin
               st_q <= ST_NORM;
            end
            ST_FW: begin
               st_q <= ST_FW;
               firmware_service_mode <= 1'b1;
            end
            default: begin
               st_q <= ST_BOOT;
            end
         endcase
      end
   end

   // ==========================================================
   // address match, bell relay, event selection
   reg [12:0] ovr_q; // manual override ms left
   reg ovr_on_q; // manual override active
   wire [1:0] emode = ctrl_q[1:0];
   wire norm = (st_q == ST_NORM);
   // outputs in normal operation
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arr_d_q <= 1'b0;
         dep_d_q <= 1'b0;
         addr_hit <= 1'b0;
         bell_relay <= 1'b0;
         event_depart <= 1'b0;
         ovr_q <= 13'h0000;
         ovr_on_q <= 1'b0;
      end else begin
         arr_d_q <= arr_p;
         dep_d_q <= dep_p;
         addr_hit <= rx_addr_vld & norm &
            ((rx_addr == addr_q) | (rx_addr == 8'h00));
         bell_relay <= norm & bell_m_q &
            ({2'b00, sec_q} < blen_q);
         if (ms_tick && ovr_q != 13'h0000) begin
            ovr_q <= ovr_q - 13'h0001;
         end
         if (norm) begin
            case (emode)
               `TMSC_EM_FREE: begin
                  ovr_on_q <= 1'b0;
                  if (arr_edge) begin
                     event_depart <= 1'b0;
                  end else if (dep_edge) begin
                     event_depart <= 1'b1;
                  end
               end
               `TMSC_EM_LOCK_ARR: begin
                  ovr_on_q <= 1'b0;
                  event_depart <= 1'b0;
               end
               `TMSC_EM_LOCK_DEP: begin
                  ovr_on_q <= 1'b0;
                  event_depart <= 1'b1;
               end
               default: begin
                  if (arr_edge | dep_edge) begin
                     event_depart <= dep_edge & ~arr_edge;
                     ovr_on_q <= 1'b1;
                     ovr_q <= OVR_MS;
                  end else if (ovr_on_q &
                     (card_done | ovr_q == 13'h0000)) begin
                     ovr_on_q <= 1'b0;
                     event_depart <= evt_val_q; // last scheduled event
                  end else if (!ovr_on_q && evt_hit_q) begin
                     event_depart <= evt_val_q;
                  end
               end
            endcase
         end
      end
   end
endmodule

// File: logic/tmsc_defines.vh
`ifndef TMSC_DEFINES_VH
`define TMSC_DEFINES_VH
// ==========================================================
// register byte offsets
`define TMSC_OFF_CTRL 8'h00
`define TMSC_OFF_ADDR 8'h04
`define TMSC_OFF_TIME 8'h08
`define TMSC_OFF_STAT 8'h0C
`define TMSC_OFF_BLEN 8'h10
`define TMSC_OFF_BELL 8'h14
`define TMSC_OFF_EVT 8'h18
// ==========================================================
// control register fields
`define TMSC_CTRL_EMODE_LSB 0
`define TMSC_CTRL_FLIP 2
`define TMSC_CTRL_WEEK 3
// event selection modes
`define TMSC_EM_FREE 2'h0
`define TMSC_EM_LOCK_ARR 2'h1
`define TMSC_EM_LOCK_DEP 2'h2
`define TMSC_EM_SCHED 2'h3
// ==========================================================
// time register fields: sec [5:0], minute [16:6], day [19:17]
`define TMSC_TIME_MIN_LSB 6
`define TMSC_TIME_DAY_LSB 17
// table entry fields
`define TMSC_ENT_EN 15
`define TMSC_ENT_EVT 11
`define TMSC_ENT_IDX_LSB 16
// ==========================================================
// reset values
`define TMSC_CTRL_RST 4'h0
`define TMSC_ADDR_RST 8'h00
`define TMSC_BLEN_RST 8'h05
// ==========================================================
// timing
`define TMSC_CLK_HZ 50000000
`define TMSC_CYC_PER_MS (`TMSC_CLK_HZ / 1000)
`define TMSC_SHOW_MS 1000
`define TMSC_ADDR_WAIT_MS 2500
`define TMSC_BEEP_MS 100
`define TMSC_OVR_MS 5000
`define TMSC_MS_PER_S 1000
`define TMSC_SYNC_CYC 4
`define TMSC_MIN_PER_DAY 1440
`endif

// File: logic/tmsc_btn_sync.v
`timescale 1ns/1ps
// ==========================================================
// three-flop synchroniser, output moves when stages 2 and 3 agree
module tmsc_btn_sync #(
   parameter N = 2
) (
   input wire pclk, // clock
   input wire presetn, // async reset, active low
   input wire [N-1:0] din, // raw pin levels
   output wire [N-1:0] dout // filtered levels
);
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_bit
         reg s1_q; // first stage, read only by s2
         reg s2_q; // second stage
         reg s3_q; // third stage
         reg out_q; // agreed level
         // shift chain and agreement
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_q <= 1'b1;
               s2_q <= 1'b1;
               s3_q <= 1'b1;
               out_q <= 1'b1;
            end else begin
               s1_q <= din[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  out_q <= s3_q;
               end
            end
         end
         assign dout[i] = out_q;
      end
   endgenerate
endmodule

// File: logic/tmsc_tbl.v
`timescale 1ns/1ps
// ==========================================================
// schedule table, one write port, one registered read port
module tmsc_tbl #(
   parameter AW = 5,
   parameter DW = 12
) (
   input wire pclk, // clock
   input wire we, // write strobe
   input wire [AW-1:0] waddr, // write index
   input wire [DW-1:0] wdata, // write entry
   input wire [AW-1:0] raddr, // scan index
   output reg [DW-1:0] rdata // entry, one cycle after raddr
);
   reg [DW-1:0] mem [0:(1<<AW)-1]; // entry storage
   integer k;
   // entries start disabled
   initial begin
      for (k = 0; k < (1<<AW); k = k + 1) begin
         mem[k] = {DW{1'b0}};
      end
   end
   // write and read
   always @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

// File: testbench/tmsc_host.sv
`timescale 1ns/1ps
// ==========================================================
// host end of the shared line, one address field per frame
module tmsc_host (
   input wire pclk, // clock
   output logic [7:0] rx_addr, // frame address field
   output logic rx_addr_vld, // frame strobe
   input wire addr_hit // terminal took the frame
);
   // line idle at start
   initial begin
      rx_addr = 8'h00;
      rx_addr_vld = 1'b0;
   end
   // callers give each drop a unique nonzero address
   // send one field, collect the answer over the next two cycles
   task frame(input logic [7:0] a, output logic h);
      @(posedge pclk);
      rx_addr <= a;
      rx_addr_vld <= 1'b1;
      @(posedge pclk);
      rx_addr <= ~a; // field no longer held after the strobe
      rx_addr_vld <= 1'b0;
      #1 h = addr_hit;
      @(posedge pclk);
      #1 h = h | addr_hit;
   endtask
endmodule

// File: testbench/tmsc_props.sv
`timescale 1ns/1ps
// ==========================================================
// port checker for the terminal control block
module tmsc_props #(
   parameter CYC_PER_MS = 10
) (
   input wire pclk, // clock
   input wire presetn, // reset, low active
   input wire rx_addr_vld, // frame strobe
   input wire [7:0] rx_addr, // frame address
   input wire addr_hit, // frame taken
   input wire firmware_service_mode, // service level
   input wire disp_show_addr, // address shown
   input wire [7:0] disp_value, // shown address
   input wire disp_flip, // turned display
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire pready, // apb ready
   input wire [7:0] paddr, // apb address
   input wire beep, // buzzer
   input wire bell_relay // relay coil
);
   reg [7:0] up_q; // cycles since reset, saturating
   reg [15:0] bc_q; // length of the current beep
   wire norm; // normal running state seen from ports
   wire ctrl_wr; // accepted write to the control word
   assign norm = up_q == 8'hFF && !disp_show_addr && !beep &&
      !firmware_service_mode;
   assign ctrl_wr = psel && penable && pready && pwrite &&
      paddr == 8'h00;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // helper counters
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_q <= 8'h00;
         bc_q <= 16'h0000;
      end else begin
         up_q <= (up_q == 8'hFF) ? up_q : up_q + 8'h01;
         bc_q <= beep ? bc_q + 16'h0001 : 16'h0000;
      end
   end
   // ==========================================================
   // assertions
   chk_svc_stays: assert property (
      firmware_service_mode |=> firmware_service_mode)
      else $error("service mode dropped");
   chk_svc_quiet: assert property (
      firmware_service_mode |-> !addr_hit && !bell_relay)
      else $error("activity in service mode");
   chk_svc_boot: assert property (
      $rose(firmware_service_mode) |-> up_q < 8'h10)
      else $error("service mode entered after boot");
   chk_hit_frame: assert property (
      addr_hit |-> $past(rx_addr_vld))
      else $error("hit without a frame");
   chk_hit_univ: assert property (
      rx_addr_vld && rx_addr == 8'h00 && norm |=> addr_hit)
      else $error("universal address missed");
   chk_flip_write: assert property (
      $changed(disp_flip) |-> $past(ctrl_wr, 2))
      else $error("flip moved without a write");
   chk_beep_len: assert property (
      $fell(beep) |-> bc_q == 100 * CYC_PER_MS)
      else $error("beep length wrong");
   chk_show_beep: assert property (
      $rose(disp_show_addr) && up_q >= 8'h10 |-> ##[0:2] beep)
      else $error("late address show without beep");
   chk_disp_step: assert property (
      $changed(disp_value) && disp_show_addr && $past(disp_show_addr)
      |-> disp_value == ($past(disp_value) >= 8'h0A ? 8'h00 :
      $past(disp_value) + 8'h01))
      else $error("address step wrong");
endmodule
bind tmsc_top tmsc_props #(.CYC_PER_MS(CYC_PER_MS)) props_u (
   .pclk, .presetn, .rx_addr_vld, .rx_addr, .addr_hit,
   .firmware_service_mode, .disp_show_addr, .disp_value, .disp_flip,
   .psel, .penable, .pwrite, .pready, .paddr, .beep, .bell_relay);

// File: testbench/terminal_mode_and_schedule_control_tb_top.sv
`timescale 1ns/1ps
`include "tmsc_defines.vh"
// ==========================================================
// bench: boots, apb, frames, bell and event control
module terminal_mode_and_schedule_control_tb_top;
   logic pclk = 1'b0, presetn = 1'b0; // clock, reset
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb
   logic [7:0] paddr = 8'h00; // apb address
   logic [31:0] pwdata = 32'h0000_0000; // apb write data
   logic btn_arrive_n = 1'b1, btn_depart_n = 1'b1; // buttons
   logic card_done = 1'b0; // card finished
   wire [31:0] prdata; // read data
   wire pready, pslverr, rx_addr_vld, addr_hit, disp_show_addr;
   wire firmware_service_mode, disp_flip, beep, bell_relay;
   wire event_depart; // event level
   wire [7:0] rx_addr, disp_value; // frame field, shown value
   int errors = 0, cmp_count = 0, n, mv, a; // counters, model
   int fq[$]; // frame addresses
   logic [31:0] r; // read result
   logic e, h; // error flag, hit
   always #10 pclk = ~pclk;
   tmsc_top #(.CYC_PER_MS(10)) dut_u (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .btn_arrive_n, .btn_depart_n, .card_done, .rx_addr,
      .rx_addr_vld, .addr_hit, .firmware_service_mode,
      .disp_show_addr, .disp_value, .disp_flip, .beep, .bell_relay,
      .event_depart);
   tmsc_host host_u (.pclk, .rx_addr, .rx_addr_vld, .addr_hit);
   // ==========================================================
   // shared tasks
   task chk(input string s, input logic [31:0] x, input logic [31:0] g);
      cmp_count++;
      if (g !== x) begin
         errors++;
         $display("wrong value %s exp %h got %h", s, x, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // wait as long as the slave needs, the watchdog ends a hang
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d);
   endtask
   task rd(input logic [7:0] ad, input logic [31:0] x, input string s);
      apb(1'b0, ad, 32'h0000_0000);
      chk(s, x, r);
   endtask
   task press(input logic dep);
      if (dep) btn_depart_n <= 1'b0;
      else btn_arrive_n <= 1'b0;
      repeat (20) @(posedge pclk);
      // release only the pressed button, the other may be held
      if (dep) btn_depart_n <= 1'b1;
      else btn_arrive_n <= 1'b1;
      repeat (20) @(posedge pclk);
   endtask
   task boot(input logic arr, input logic dep);
      @(posedge pclk);
      presetn <= 1'b0;
      btn_arrive_n <= ~arr;
      btn_depart_n <= ~dep;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (20) @(posedge pclk);
   endtask
   task tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ==========================================================
   // hang guard
   initial begin
      repeat (95000) @(posedge pclk);
      errors++;
      $display("watchdog expired");
      tally_and_finish;
   end
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(26010));
      boot(1'b1, 1'b0);
      chk("service", 1, firmware_service_mode);
      boot(1'b1, 1'b1);
      chk("service", 1, firmware_service_mode);
      press(1'b1);
      press(1'b0);
      host_u.frame(8'h00, h);
      chk("service hit", 0, h);
      chk("service", 1, firmware_service_mode);
      $display("test service done");
      boot(1'b0, 1'b1);
      wr(`TMSC_OFF_ADDR, 32'h0000_000C);
      for (n = 0; n < 30000 && beep !== 1'b1; n++) @(posedge pclk);
      chk("beep delay", 1, n > 24000 && n < 26000);
      repeat (5) @(posedge pclk);
      chk("show", 1, disp_show_addr);
      chk("shown", 8'h0C, disp_value);
      mv = 12;
      repeat (14) begin
         press(1'b0);
         mv = (mv >= 10) ? 0 : mv + 1;
         chk("step", mv, disp_value);
      end
      btn_depart_n <= 1'b1;
      repeat (20) @(posedge pclk);
      chk("show off", 0, disp_show_addr);
      rd(`TMSC_OFF_ADDR, mv, "stored");
      host_u.frame(mv[7:0], h);
      chk("hit", 1, h);
      $display("test address setting done");
      boot(1'b0, 1'b0);
      chk("normal", 0, firmware_service_mode);
      chk("boot show", 1, disp_show_addr);
      for (n = 0; n < 12000 && disp_show_addr !== 1'b0; n++)
         @(posedge pclk);
      chk("show len", 1, n > 9000 && n < 11000);
      a = 1 + $urandom % 253;
      wr(`TMSC_OFF_ADDR, a);
      rd(`TMSC_OFF_ADDR, a, "addr");
      fq = '{0, a, a + 1, 255};
      foreach (fq[i]) begin
         host_u.frame(fq[i][7:0], h);
         chk("hit", fq[i] == 0 || fq[i] == a, h);
      end
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("slverr", 1, e);
      $display("test address match done");
      wr(`TMSC_OFF_CTRL, 32'h0000_0004);
      repeat (3) @(posedge pclk);
      chk("flip", 1, disp_flip);
      wr(`TMSC_OFF_CTRL, 32'h0000_0000);
      press(1'b1);
      chk("free", 1, event_depart);
      press(1'b0);
      chk("free", 0, event_depart);
      for (mv = 1; mv <= 2; mv++) begin
         wr(`TMSC_OFF_CTRL, mv);
         repeat (5) @(posedge pclk);
         chk("lock", mv == 2, event_depart);
         press(mv == 1);
         chk("lock", mv == 2, event_depart);
      end
      wr(`TMSC_OFF_TIME, 32'h0004_9600);
      wr(`TMSC_OFF_BELL, 32'h0000_8258);
      repeat (100) @(posedge pclk);
      chk("bell", 1, bell_relay);
      wr(`TMSC_OFF_BELL, 32'h0000_0258);
      repeat (100) @(posedge pclk);
      chk("bell", 0, bell_relay);
      wr(`TMSC_OFF_CTRL, 32'h0000_0008);
      wr(`TMSC_OFF_BELL, 32'h0000_8258);
      repeat (100) @(posedge pclk);
      chk("week", 0, bell_relay);
      wr(`TMSC_OFF_BELL, 32'h0042_8258);
      repeat (100) @(posedge pclk);
      chk("week", 1, bell_relay);
      press(1'b0); // arrival first, so the schedule must move it
      wr(`TMSC_OFF_EVT, 32'h0003_8A58);
      wr(`TMSC_OFF_CTRL, 32'h0000_0003);
      repeat (100) @(posedge pclk);
      chk("sched", 1, event_depart);
      press(1'b0);
      chk("override", 0, event_depart);
      card_done <= 1'b1;
      @(posedge pclk);
      card_done <= 1'b0;
      repeat (100) @(posedge pclk);
      chk("resume", 1, event_depart);
      $display("test controls done");
      tally_and_finish;
   end
endmodule
